// ===== hw/dhb_pkg.sv
package dhb_pkg;

	// ------------------------------------------------------------
	// interface selection codes, as strapped
	// ------------------------------------------------------------
	typedef enum logic [2:0]
	{
		MODE_SPI4 = 3'b000,
		MODE_SPI3 = 3'b001,
		MODE_I2C = 3'b010,
		MODE_P6800 = 3'b100,
		MODE_P8080 = 3'b110
	} dhb_mode_t;

	// ------------------------------------------------------------
	// parallel bus phase
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		PH_IDLE = 2'b00,
		PH_WRITE = 2'b01,
		PH_READ = 2'b10
	} dhb_phase_t;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int BUF_AW = 13;
	localparam int BUF_WORDS = 8192;
	localparam int SYNC_W = 18;

	// ------------------------------------------------------------
	// serial framing
	// ------------------------------------------------------------
	localparam logic [3:0] SPI4_LAST_BIT = 4'h7;
	localparam logic [3:0] SPI3_LAST_BIT = 4'h8;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 8000;
	localparam int DISP_TICK_NS = 400;
	localparam int DISP_TICK_CYC = (DISP_TICK_NS * 1000) / CLK_PERIOD_PS;
	localparam logic [7:0] DISP_TICK_LAST = 8'(DISP_TICK_CYC - 1);
	localparam int FRAME_TICKS = 2048;
	localparam logic [15:0] SYNC_TICKS = 16'h0008;

	// ------------------------------------------------------------
	// values after reset
	// ------------------------------------------------------------
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [BUF_AW-1:0] PTR_RST = 13'h0000;

endpackage

// ===== hw/dhb_pin_sync.sv
`timescale 1ns/1ps
// three-stage pin synchroniser; a bit moves only once stages two and three agree
module dhb_pin_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level_q
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] agree;

	// agreement mask; stage one is seen only by stage two
	assign agree = ~(s2_q ^ s3_q);

	// shift chain and filtered level
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			level_q <= '0;
		end
		else
		begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			level_q <= (level_q & ~agree) | (s3_q & agree);
		end
	end

endmodule

// ===== hw/dhb_buffer.sv
`timescale 1ns/1ps
// display buffer store, one port, registered read
module dhb_buffer (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic we,
	input wire logic [dhb_pkg::BUF_AW-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata_q
);

	logic [7:0] mem [dhb_pkg::BUF_WORDS];

	// array write; no reset so it maps onto a ram macro
	always_ff @(posedge ref_clk)
	begin
		if (we)
		begin
			mem[addr] <= wdata;
		end
	end

	// read data always follows the address one cycle late
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			rdata_q <= dhb_pkg::BYTE_RST;
		end
		else
		begin
			rdata_q <= mem[addr];
		end
	end

endmodule

// ===== hw/dhb_host_if.sv
`timescale 1ns/1ps
module dhb_host_if #(
	parameter int FRAME_TICKS = dhb_pkg::FRAME_TICKS
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [2:0] interface_select_straps,
	input wire logic cs_low,
	input wire logic init_low,
	input wire logic dc_sel,
	input wire logic rw_wr_low,
	input wire logic e_rd_low,
	input wire logic [7:0] data_in,
	input wire logic osc_source_select,
	input wire logic ext_clock_in,
	input wire logic [7:0] status_in,
	input wire logic ptr_load,
	input wire logic [dhb_pkg::BUF_AW-1:0] ptr_value,
	output logic [7:0] data_out,
	output logic data_oe,
	output logic cmd_valid,
	output logic [7:0] cmd_byte,
	output logic frame_sync_out,
	output logic ext_clk_used,
	output logic [2:0] iface_mode,
	output logic init_active
);

	// ------------------------------------------------------------
	// pin synchronisation
	// ------------------------------------------------------------
	logic [dhb_pkg::SYNC_W-1:0] pins_f;
	logic [7:0] d_f;
	logic [2:0] straps_f;
	logic cs_low_f, init_low_f, dc_f, rw_f, e_f, osc_f, ext_f;

	dhb_pin_sync #(.W(dhb_pkg::SYNC_W)) u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.pin_in({data_in, cs_low, init_low, dc_sel, rw_wr_low, e_rd_low, interface_select_straps,
			osc_source_select, ext_clock_in}),
		.level_q(pins_f)
	);

	assign {d_f, cs_low_f, init_low_f, dc_f, rw_f, e_f, straps_f, osc_f, ext_f} = pins_f;

	// ------------------------------------------------------------
	// edge detection and soft reset
	// ------------------------------------------------------------
	logic e_prev_q, rw_prev_q, ext_prev_q;
	logic soft_rst, sel;
	logic e_rise, e_fall, rw_rise, rw_fall, ext_rise;

	assign soft_rst = ~init_low_f;
	assign sel = ~cs_low_f;
	assign e_rise = e_f & ~e_prev_q;
	assign e_fall = ~e_f & e_prev_q;
	assign rw_rise = rw_f & ~rw_prev_q;
	assign rw_fall = ~rw_f & rw_prev_q;
	assign ext_rise = ext_f & ~ext_prev_q;

	// previous filtered levels for edge finding
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			e_prev_q <= 1'b0;
			rw_prev_q <= 1'b0;
			ext_prev_q <= 1'b0;
		end
		else
		begin
			e_prev_q <= e_f;
			rw_prev_q <= rw_f;
			ext_prev_q <= ext_f;
		end
	end

	// ------------------------------------------------------------
	// interface mode
	// ------------------------------------------------------------
	dhb_pkg::dhb_mode_t mode_q;
	logic mode_taken_q;

	// straps are static; taken while init is held and once more in the first cycle after,
	// since init and straps leave the pin filter on the same edge
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			mode_q <= dhb_pkg::MODE_SPI4;
			mode_taken_q <= 1'b0;
		end
		else if (soft_rst || !mode_taken_q)
		begin
			mode_q <= dhb_pkg::dhb_mode_t'(straps_f);
			mode_taken_q <= !soft_rst;
		end
	end

	// ------------------------------------------------------------
	// parallel bus sequencing
	// ------------------------------------------------------------
	dhb_pkg::dhb_phase_t phase_q;
	logic par_wr, par_rd_end;

	// 6800: e is the strobe, rw picks direction; 8080: rw is write strobe, e is read strobe
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			phase_q <= dhb_pkg::PH_IDLE;
		else if (soft_rst || !sel)
			phase_q <= dhb_pkg::PH_IDLE;
		else
		begin
			unique case (phase_q)
				dhb_pkg::PH_IDLE:
					if (mode_q == dhb_pkg::MODE_P6800 && e_rise)
						phase_q <= rw_f ? dhb_pkg::PH_READ : dhb_pkg::PH_WRITE;
					else if (mode_q == dhb_pkg::MODE_P8080 && rw_fall)
						phase_q <= dhb_pkg::PH_WRITE;
					else if (mode_q == dhb_pkg::MODE_P8080 && !e_f)
						phase_q <= dhb_pkg::PH_READ;
				dhb_pkg::PH_WRITE, dhb_pkg::PH_READ:
					if (par_wr || par_rd_end)
						phase_q <= dhb_pkg::PH_IDLE;
				default:
					phase_q <= dhb_pkg::PH_IDLE;
			endcase
		end
	end

	// closing edges; data was synchronised alongside the strobes so it lines up
	assign par_wr = sel && phase_q == dhb_pkg::PH_WRITE &&
		((mode_q == dhb_pkg::MODE_P6800 && e_fall) ||
		(mode_q == dhb_pkg::MODE_P8080 && rw_rise));
	assign par_rd_end = sel && phase_q == dhb_pkg::PH_READ &&
		((mode_q == dhb_pkg::MODE_P6800 && e_fall) ||
		(mode_q == dhb_pkg::MODE_P8080 && e_f));

	// ------------------------------------------------------------
	// serial shifter
	// ------------------------------------------------------------
	logic serial_mode, sck_rise, ser_wr, ser_is_data, d_prev0_q;
	logic [3:0] bit_cnt_q;
	logic [8:0] shreg_q;
	logic [7:0] ser_byte;

	assign serial_mode = mode_q == dhb_pkg::MODE_SPI4 || mode_q == dhb_pkg::MODE_SPI3;
	assign sck_rise = serial_mode && sel && d_f[0] && !d_prev0_q;
	assign ser_byte = {shreg_q[6:0], d_f[1]};
	assign ser_wr = sck_rise && (mode_q == dhb_pkg::MODE_SPI4 ? bit_cnt_q == dhb_pkg::SPI4_LAST_BIT :
		bit_cnt_q == dhb_pkg::SPI3_LAST_BIT);
	assign ser_is_data = mode_q == dhb_pkg::MODE_SPI4 ? dc_f : shreg_q[7];

	// shift register and bit count, msb first
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			bit_cnt_q <= 4'h0;
			shreg_q <= 9'h000;
			d_prev0_q <= 1'b0;
		end
		else
		begin
			d_prev0_q <= d_f[0];
			if (soft_rst || !sel)
				bit_cnt_q <= 4'h0;
			else if (sck_rise)
			begin
				shreg_q <= {shreg_q[7:0], d_f[1]};
				bit_cnt_q <= ser_wr ? 4'h0 : bit_cnt_q + 4'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// write routing and buffer pointer
	// ------------------------------------------------------------
	logic wr_any, wr_is_data, buf_we;
	logic [7:0] wr_byte, buf_rdata_q, rd_latch_q;
	logic [dhb_pkg::BUF_AW-1:0] ptr_q;

	// I2C framing is not handled here, so that mode never produces a write
	assign wr_any = !soft_rst && (par_wr || ser_wr);
	assign wr_is_data = par_wr ? dc_f : ser_is_data;
	assign wr_byte = par_wr ? d_f : ser_byte;
	assign buf_we = wr_any && wr_is_data;

	dhb_buffer u_buf (.ref_clk(ref_clk), .rst(rst), .we(buf_we), .addr(ptr_q), .wdata(wr_byte),
		.rdata_q(buf_rdata_q));

	// command bytes leave as a one-cycle strobe for the decoder
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			cmd_valid <= 1'b0;
			cmd_byte <= dhb_pkg::BYTE_RST;
		end
		else
		begin
			cmd_valid <= wr_any && !wr_is_data;
			if (wr_any && !wr_is_data)
				cmd_byte <= wr_byte;
		end
	end

	// pointer steps after each buffer access; the decoder may reload it
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			ptr_q <= dhb_pkg::PTR_RST;
		else if (soft_rst)
			ptr_q <= dhb_pkg::PTR_RST;
		else if (ptr_load)
			ptr_q <= ptr_value;
		else if (buf_we || (par_rd_end && dc_f))
			ptr_q <= ptr_q + 13'h0001;
	end

	// read pipeline: the host sees the latch, which refills at the end of each data read,
	// so the first read after a pointer change returns stale data
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			rd_latch_q <= dhb_pkg::BYTE_RST;
		else if (par_rd_end && dc_f && !soft_rst)
			rd_latch_q <= buf_rdata_q;
	end

	// bus drive only for parallel reads; serial modes never drive
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			data_oe <= 1'b0;
			data_out <= dhb_pkg::BYTE_RST;
		end
		else
		begin
			data_oe <= !soft_rst && sel && phase_q == dhb_pkg::PH_READ;
			data_out <= dc_f ? rd_latch_q : status_in;
		end
	end

	// ------------------------------------------------------------
	// display timing and frame sync
	// ------------------------------------------------------------
	logic [7:0] div_q;
	logic int_tick, disp_tick;
	logic [15:0] frame_cnt_q;

	assign int_tick = div_q == dhb_pkg::DISP_TICK_LAST;
	assign disp_tick = osc_f ? int_tick : ext_rise;

	// internal oscillator stands in as a divided enable
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			div_q <= 8'h00;
		else
			div_q <= int_tick ? 8'h00 : div_q + 8'h01;
	end

	// frame counter; sync pulse spans the first ticks of every frame
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			frame_cnt_q <= 16'h0000;
			frame_sync_out <= 1'b0;
		end
		else if (soft_rst)
		begin
			frame_cnt_q <= 16'h0000;
			frame_sync_out <= 1'b0;
		end
		else
		begin
			if (disp_tick)
				frame_cnt_q <= (frame_cnt_q == 16'(FRAME_TICKS - 1)) ? 16'h0000 : frame_cnt_q + 16'h0001;
			frame_sync_out <= frame_cnt_q < dhb_pkg::SYNC_TICKS;
		end
	end

	// ------------------------------------------------------------
	// status outputs
	// ------------------------------------------------------------
	// mode is reported so the board can check its straps; I2C pins are D0 clock, D1/D2 data
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			ext_clk_used <= 1'b0;
			iface_mode <= 3'h0;
			init_active <= 1'b1;
		end
		else
		begin
			ext_clk_used <= !osc_f;
			iface_mode <= mode_q;
			init_active <= soft_rst;
		end
	end

endmodule

// ===== bench/dhb_host_if_asserts.sv
`timescale 1ns/1ps
// pin filters add a few cycles, so each bound on a pin below leaves that slack
module dhb_host_if_asserts (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic cs_low,
	input wire logic init_low,
	input wire logic rw_wr_low,
	input wire logic osc_source_select,
	input wire logic data_oe,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_byte,
	input wire logic frame_sync_out,
	input wire logic ext_clk_used,
	input wire logic [2:0] iface_mode,
	input wire logic init_active
);
	// one clock domain, so clocking and reset are given once
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	AST_CS_IDLE: assert property (cs_low [*8] |-> !data_oe)
		else $error("bus driven while deselected");
	AST_SERIAL_QUIET: assert property (iface_mode[2:1] == 2'b00 |-> !data_oe)
		else $error("serial mode drove the bus");
	AST_I2C_SILENT: assert property (iface_mode == dhb_pkg::MODE_I2C |-> !cmd_valid)
		else $error("command taken in I2C mode");
	AST_P6800_WRITE: assert property ((iface_mode == dhb_pkg::MODE_P6800 && !rw_wr_low) [*8] |-> !data_oe)
		else $error("bus driven during a 6800 write");
	AST_CMD_HOLD: assert property ($changed(cmd_byte) && !init_active && !$past(init_active) |-> cmd_valid)
		else $error("command byte moved without a pulse");
	AST_OSC_EXT: assert property ((!osc_source_select) [*8] |-> ext_clk_used)
		else $error("external clock select ignored");
	AST_INIT_SEEN: assert property ((!init_low) [*8] |-> init_active)
		else $error("init input ignored");
	AST_SYNC_WIDTH: assert property ($rose(frame_sync_out) |-> frame_sync_out [*8])
		else $error("frame sync pulse too short");
endmodule

// ===== bench/dhb_mcu.sv
`timescale 1ns/1ps
// host side of the bus; every pin moves on the falling clock edge
module dhb_mcu (
	input wire logic ref_clk,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	output logic cs_low,
	output logic dc_sel,
	output logic rw_wr_low,
	output logic e_rd_low,
	output logic [7:0] data_in
);
	initial
	begin
		cs_low = 1'b1;
		dc_sel = 1'b0;
		rw_wr_low = 1'b0;
		e_rd_low = 1'b0;
		data_in = 8'h00;
	end
	// rest levels: 8080 strobes high, otherwise tied low
	task automatic rest(input bit m80);
		rw_wr_low = m80;
		e_rd_low = m80;
	endtask
	// one parallel byte; strobes stand at least 6 cycles so the pin filter sees them
	task automatic px(input bit m80, input bit rd, input bit sel, input bit dc, input logic [7:0] wd,
		output logic [7:0] rdv);
		int i;
		rdv = 8'hXX;
		dc_sel = dc;
		data_in = rd ? ~data_in : wd;
		cs_low = !sel;
		rw_wr_low = m80 | rd;
		e_rd_low = m80;
		repeat (2) @(negedge ref_clk);
		if (!m80)
			e_rd_low = 1'b1;
		else if (rd)
			e_rd_low = 1'b0;
		else
			rw_wr_low = 1'b0;
		repeat (6) @(negedge ref_clk);
		for (i = 0; i < 20 && rd && data_oe !== 1'b1; i++)
			@(negedge ref_clk);
		// a read that never drives the bus hands back unknowns, which the caller's compare counts
		if (rd && data_oe === 1'b1)
			rdv = data_out;
		e_rd_low = m80;
		rw_wr_low = m80 | rd;
		repeat (6) @(negedge ref_clk);
		cs_low = 1'b1;
		data_in = ~data_in;
		// deselect must stand long enough for the pin filter before the next byte
		repeat (6) @(negedge ref_clk);
	endtask
	// serial frame msb first, 80 ns per bit; the data line flips once the frame ends
	task automatic ser(input bit dc, input int n, input logic [8:0] b);
		int i;
		dc_sel = dc;
		cs_low = 1'b0;
		for (i = n - 1; i >= 0; i--)
		begin
			data_in = {6'h00, b[i], 1'b0};
			repeat (5) @(negedge ref_clk);
			data_in = {6'h00, b[i], 1'b1};
			repeat (5) @(negedge ref_clk);
		end
		data_in = {6'h00, ~b[0], 1'b0};
		repeat (5) @(negedge ref_clk);
		cs_low = 1'b1;
		repeat (5) @(negedge ref_clk);
	endtask
endmodule

// ===== bench/tb_dhb_host_if.sv
`timescale 1ns/1ps
module tb_dhb_host_if;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] straps = 3'b100;
	logic init_low = 1'b1;
	logic osc = 1'b1;
	logic ext_clk = 1'b0;
	logic [7:0] status = 8'h5A;
	logic ptr_load = 1'b0;
	logic [12:0] ptr_value = 13'h0000;
	logic cs_low, dc_sel, rw_wr_low, e_rd_low, data_oe, cmd_valid, frame_sync_out, ext_clk_used, init_active;
	logic [7:0] data_in, data_out, cmd_byte, rd;
	logic [2:0] iface_mode;
	logic [7:0] cmd_q[$];
	int bad_count = 0;
	int check_count = 0;
	always #4 ref_clk = ~ref_clk;
	// link clock, offset so its edges never meet the core clock
	initial #3 forever #40 ext_clk = ~ext_clk;
	dhb_host_if #(.FRAME_TICKS(16)) i_dhb_host_if (.ref_clk(ref_clk), .rst(rst),
		.interface_select_straps(straps), .cs_low(cs_low), .init_low(init_low), .dc_sel(dc_sel),
		.rw_wr_low(rw_wr_low), .e_rd_low(e_rd_low), .data_in(data_in), .osc_source_select(osc),
		.ext_clock_in(ext_clk), .status_in(status), .ptr_load(ptr_load), .ptr_value(ptr_value),
		.data_out(data_out), .data_oe(data_oe), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
		.frame_sync_out(frame_sync_out), .ext_clk_used(ext_clk_used), .iface_mode(iface_mode),
		.init_active(init_active));
	dhb_mcu i_dhb_mcu (.ref_clk(ref_clk), .data_out(data_out), .data_oe(data_oe), .cs_low(cs_low),
		.dc_sel(dc_sel), .rw_wr_low(rw_wr_low), .e_rd_low(e_rd_low), .data_in(data_in));
	// command pulses are queued so a task can judge them after its bus cycle; mid-cycle the pulse has settled
	always @(negedge ref_clk)
		if (cmd_valid === 1'b1)
			cmd_q.push_back(cmd_byte);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		if (bad_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cmd_is(input logic [7:0] exp);
		int i;
		for (i = 0; i < 60 && cmd_q.size() == 0; i++)
			@(negedge ref_clk);
		if (cmd_q.size() == 0)
		begin
			bad_count++;
			tally_and_finish();
		end
		else
			chk(cmd_q.pop_front(), exp);
	endtask
	task automatic no_cmd;
		repeat (20) @(negedge ref_clk);
		chk(8'(cmd_q.size()), 8'h00);
	endtask
	task automatic ptr_at(input logic [12:0] p);
		ptr_value = p;
		ptr_load = 1'b1;
		@(negedge ref_clk);
		ptr_load = 1'b0;
	endtask
	// straps are taken again only by a soft reset, so each mode change goes through one
	task automatic mode(input logic [2:0] m);
		straps = m;
		init_low = 1'b0;
		i_dhb_mcu.rest(m == dhb_pkg::MODE_P8080);
		repeat (12) @(negedge ref_clk);
		chk({7'h00, init_active}, 8'h01);
		init_low = 1'b1;
		repeat (20) @(negedge ref_clk);
		chk({5'h00, iface_mode}, {5'h00, m});
	endtask
	task automatic t_6800;
		mode(dhb_pkg::MODE_P6800);
		i_dhb_mcu.px(0, 0, 1, 0, 8'hA5, rd);
		cmd_is(8'hA5);
		ptr_at(13'h0010);
		i_dhb_mcu.px(0, 0, 1, 1, 8'h3C, rd);
		i_dhb_mcu.px(0, 0, 1, 1, 8'hC3, rd);
		ptr_at(13'h0010);
		i_dhb_mcu.px(0, 1, 1, 1, 8'h00, rd);
		i_dhb_mcu.px(0, 1, 1, 1, 8'h00, rd);
		chk(rd, 8'h3C);
		i_dhb_mcu.px(0, 1, 1, 1, 8'h00, rd);
		chk(rd, 8'hC3);
		i_dhb_mcu.px(0, 1, 1, 0, 8'h00, rd);
		chk(rd, 8'h5A);
		i_dhb_mcu.px(0, 0, 0, 0, 8'h77, rd);
		no_cmd();
	endtask
	// pointer at the top of the buffer
	task automatic t_8080;
		mode(dhb_pkg::MODE_P8080);
		i_dhb_mcu.px(1, 0, 1, 0, 8'h96, rd);
		cmd_is(8'h96);
		ptr_at(13'h1FFF);
		i_dhb_mcu.px(1, 0, 1, 1, 8'hE1, rd);
		ptr_at(13'h1FFF);
		i_dhb_mcu.px(1, 1, 1, 1, 8'h00, rd);
		i_dhb_mcu.px(1, 1, 1, 1, 8'h00, rd);
		chk(rd, 8'hE1);
		status = 8'hC7;
		i_dhb_mcu.px(1, 1, 1, 0, 8'h00, rd);
		chk(rd, 8'hC7);
	endtask
	// serial data lands at pointer zero after each soft reset; the 3-wire byte is read back in 6800 mode
	task automatic t_serial;
		mode(dhb_pkg::MODE_SPI4);
		i_dhb_mcu.ser(1'b0, 8, 9'h01B);
		cmd_is(8'h1B);
		i_dhb_mcu.ser(1'b1, 8, 9'h042);
		no_cmd();
		i_dhb_mcu.ser(1'b0, 3, 9'h005);
		i_dhb_mcu.ser(1'b0, 8, 9'h081);
		cmd_is(8'h81);
		mode(dhb_pkg::MODE_SPI3);
		i_dhb_mcu.ser(1'b0, 9, 9'h0D4);
		cmd_is(8'hD4);
		i_dhb_mcu.ser(1'b0, 9, 9'h111);
		no_cmd();
		mode(dhb_pkg::MODE_I2C);
		i_dhb_mcu.ser(1'b0, 8, 9'h0A0);
		no_cmd();
		mode(dhb_pkg::MODE_P6800);
		i_dhb_mcu.px(0, 1, 1, 1, 8'h00, rd);
		i_dhb_mcu.px(0, 1, 1, 1, 8'h00, rd);
		chk(rd, 8'h11);
	endtask
	// length of the next sync pulse in core cycles
	task automatic sync_len(output int n);
		int t;
		n = 0;
		t = 0;
		while (t < 3000 && frame_sync_out !== 1'b0)
		begin
			t++;
			@(negedge ref_clk);
		end
		while (t < 3000 && frame_sync_out !== 1'b1)
		begin
			t++;
			@(negedge ref_clk);
		end
		while (t < 3000 && frame_sync_out === 1'b1)
		begin
			t++;
			n++;
			@(negedge ref_clk);
		end
		if (t >= 3000)
		begin
			bad_count++;
			tally_and_finish();
		end
	endtask
	// eight ticks: 50 cycles each inside, one link clock period each outside
	task automatic t_frame;
		int n;
		chk({7'h00, ext_clk_used}, 8'h00);
		sync_len(n);
		chk(8'((n + 25) / 50), 8'h08);
		osc = 1'b0;
		repeat (20) @(negedge ref_clk);
		chk({7'h00, ext_clk_used}, 8'h01);
		sync_len(n);
		chk(8'((n + 5) / 10), 8'h08);
	endtask
	initial
	begin
		repeat (20) @(negedge ref_clk);
		rst = 1'b0;
		repeat (12) @(negedge ref_clk);
		chk({7'h00, init_active}, 8'h00);
		t_6800();
		t_8080();
		t_serial();
		t_frame();
		tally_and_finish();
	end
endmodule

bind dhb_host_if dhb_host_if_asserts i_dhb_host_if_asserts (.ref_clk(ref_clk), .rst(rst), .cs_low(cs_low),
	.init_low(init_low), .rw_wr_low(rw_wr_low), .osc_source_select(osc_source_select), .data_oe(data_oe),
	.cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .frame_sync_out(frame_sync_out), .ext_clk_used(ext_clk_used),
	.iface_mode(iface_mode), .init_active(init_active));
